// ### rtl/adc_sample_sequencer.sv
// Sample sequencer: step tables, arbitration, sample FIFOs and flags
// Function
// - Each sequence returns results through its own FIFO, one sample per read.
// - Software can read how many samples a sequence FIFO holds.
// - A disabled sequence ignores its trigger; a run already under way still captures its samples.
// - An enabled sequence starts its steps when its trigger is seen.
// - A trigger while unread samples remain sets the overflow flag.
// - Overflow stays set until software clears it; no other effect.
// - Reading an empty sequence FIFO sets the underflow flag.
// - Underflow stays set until software clears it; no other effect.
// - Each step has a bit choosing differential or single-ended input.
// - Each step selects one of eight analog input channels.
// - Each step may select the temperature sensor instead of a channel.
// - A step with the end bit set ends the sequence.
// - A step with its interrupt bit raises the sequence interrupt when done.
// - Steps run in ascending order; 8, 4, 4, 1 valid steps per sequence.
// - Step settings are applied when that step is converted.
// - Sequences 0 to 3 capture at most 8, 4, 4, 1 samples.
// - Pending sequences are served by priority, 0 highest; ties go to the lower sequence.
`default_nettype none
module adc_sample_sequencer #(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic [7:0]             addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output var  logic [31:0]            rdata,
  input  wire logic [3:0]             trig,
  output var  logic                   conv_start,
  output var  adc_seq_pkg::conv_req_t conv_req,
  input  wire logic                   conv_done,
  input  wire logic [SAMPLE_W-1:0]    conv_data,
  output var  logic                   irq
);
  if (SAMPLE_W < 1 || SAMPLE_W > 32)
  begin : g_bad_width
    $error("SAMPLE_W must lie in 1..32");
  end

  typedef enum logic [1:0] {IDLE, START, WAIT} state_t;

  adc_seq_pkg::step_t cfg [adc_seq_pkg::NSEQ][adc_seq_pkg::MAX_STEPS];
  logic [SAMPLE_W-1:0] mem [adc_seq_pkg::NSEQ][adc_seq_pkg::MAX_STEPS];
  logic [2:0] rptr [adc_seq_pkg::NSEQ];
  logic [2:0] wptr [adc_seq_pkg::NSEQ];
  logic [3:0] cnt  [adc_seq_pkg::NSEQ];

  state_t     state;
  logic [1:0] cur;
  logic [2:0] step;
  logic [3:0] en;
  logic [7:0] prio;
  logic [3:0] pending;
  logic [3:0] ovf;
  logic [3:0] udf;
  logic [3:0] raw;
  logic [3:0] mask;

  logic [3:0] trg;
  logic [3:0] hit;
  logic [3:0] nonempty;
  logic [3:0] full;
  logic [3:0] pop;
  logic [3:0] udf_ev;
  logic [3:0] pick;
  logic [3:0] done_irq;
  logic [1:0] win;
  logic       push;
  adc_seq_pkg::step_t cs;
  logic [7:0] soff;

  // Aligned word inside a 16-byte group of four per-sequence registers
  function automatic logic in_group(input logic [7:0] a,
                                    input logic [7:0] base);
    return a[7:4] == base[7:4] && a[1:0] == 2'b00;
  endfunction : in_group

  function automatic logic [2:0] next_ptr(input logic [2:0] p,
                                          input logic [1:0] s);
    return ({1'b0, p} == adc_seq_pkg::seq_depth(s) - 4'd1) ? 3'd0
                                                           : p + 3'd1;
  endfunction : next_ptr

  // Lowest priority value wins; ties go to the lower sequence number
  function automatic logic [1:0] pick_winner(input logic [3:0] req,
                                             input logic [7:0] pr);
    logic [1:0] w;
    logic [2:0] best;
    w = 2'd0;
    best = 3'd4;
    for (int i = 0; i < adc_seq_pkg::NSEQ; i++)
    begin
      if (req[i] && {1'b0, pr[2*i +: 2]} < best)
      begin
        w = 2'(i);
        best = {1'b0, pr[2*i +: 2]};
      end
    end
    return w;
  endfunction : pick_winner

  always_comb
  begin
    trg = trig | ((wr && addr == adc_seq_pkg::A_SWTRIG) ? wdata[3:0]
                                                         : 4'h0);
    hit = trg & en;
    cs = cfg[cur][step];
    push = state == WAIT && conv_done;
    soff = addr - adc_seq_pkg::A_STEP;
    win = pick_winner(pending & en, prio);
    pick = (state == IDLE && |(pending & en)) ? 4'h1 << win : 4'h0;
    done_irq = (push && cs.step_irq_on_done) ? 4'h1 << cur : 4'h0;
    for (int s = 0; s < adc_seq_pkg::NSEQ; s++)
    begin
      nonempty[s] = cnt[s] != 4'd0;
      full[s] = cnt[s] == adc_seq_pkg::seq_depth(2'(s));
      pop[s] = rd && in_group(addr, adc_seq_pkg::A_FIFO)
               && addr[3:2] == 2'(s) && nonempty[s];
      udf_ev[s] = rd && in_group(addr, adc_seq_pkg::A_FIFO)
                  && addr[3:2] == 2'(s) && !nonempty[s];
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      en <= adc_seq_pkg::ENABLE_RST;
      prio <= adc_seq_pkg::PRIO_RST;
      mask <= adc_seq_pkg::MASK_RST;
    end
    else if (wr)
    begin
      if (addr == adc_seq_pkg::A_ENABLE)
        en <= wdata[3:0];
      if (addr == adc_seq_pkg::A_PRIO)
        prio <= wdata[7:0];
      if (addr == adc_seq_pkg::A_IRQ_MASK)
        mask <= wdata[3:0];
    end
  end

  // Step tables; writes past a sequence's last valid step are dropped
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int s = 0; s < adc_seq_pkg::NSEQ; s++)
        for (int t = 0; t < adc_seq_pkg::MAX_STEPS; t++)
          cfg[s][t] <= '0;
    end
    else if (wr && soff < adc_seq_pkg::STEP_SPAN && soff[1:0] == 2'b00
             && {1'b0, soff[4:2]} < adc_seq_pkg::seq_depth(soff[6:5]))
      cfg[soff[6:5]][soff[4:2]] <= wdata[6:0];
  end

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ovf <= 4'h0;
      udf <= 4'h0;
    end
    else
    begin
      ovf <= (ovf & ~((wr && addr == adc_seq_pkg::A_FLAGS)
              ? wdata[adc_seq_pkg::F_OVF +: 4] : 4'h0))
             | (hit & nonempty);
      udf <= (udf & ~((wr && addr == adc_seq_pkg::A_FLAGS)
              ? wdata[adc_seq_pkg::F_UDF +: 4] : 4'h0))
             | udf_ev;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      raw <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      raw <= (raw & ~((wr && addr == adc_seq_pkg::A_IRQ_RAW)
              ? wdata[3:0] : 4'h0)) | done_irq;
      irq <= |(raw & mask);
    end
  end

  // A trigger landing on the cycle its sequence is picked stays pending
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      pending <= 4'h0;
    else
      pending <= (pending & ~pick) | hit;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= IDLE;
      cur <= 2'd0;
      step <= 3'd0;
      conv_start <= 1'b0;
      conv_req <= '0;
    end
    else
    begin
      conv_start <= 1'b0;
      unique case (state)
        IDLE:
          if (|(pending & en))
          begin
            cur <= win;
            step <= 3'd0;
            state <= START;
          end
        START:
        begin
          conv_start <= 1'b1;
          conv_req.chan <= cs.step_input_sel;
          conv_req.diff <= cs.step_diff_sel;
          conv_req.temp <= cs.step_temp_sensor_sel;
          state <= WAIT;
        end
        WAIT:
          if (conv_done)
          begin
            if (cs.step_last_marker || {1'b0, step} ==
                adc_seq_pkg::seq_depth(cur) - 4'd1)
              state <= IDLE;
            else
            begin
              step <= step + 3'd1;
              state <= START;
            end
          end
      endcase
    end
  end

  // A full FIFO drops the new sample; the drop itself does not set overflow
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int s = 0; s < adc_seq_pkg::NSEQ; s++)
      begin
        rptr[s] <= 3'd0;
        wptr[s] <= 3'd0;
        cnt[s] <= 4'd0;
      end
    end
    else
    begin
      for (int s = 0; s < adc_seq_pkg::NSEQ; s++)
      begin
        if (push && cur == 2'(s) && !full[s])
        begin
          mem[s][wptr[s]] <= conv_data;
          wptr[s] <= next_ptr(wptr[s], 2'(s));
        end
        if (pop[s])
          rptr[s] <= next_ptr(rptr[s], 2'(s));
        cnt[s] <= cnt[s] + {3'd0, push && cur == 2'(s) && !full[s]}
                  - {3'd0, pop[s]};
      end
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata <= 32'h0;
    else if (!rd)
      rdata <= 32'h0;
    else if (in_group(addr, adc_seq_pkg::A_FIFO))
      rdata <= nonempty[addr[3:2]]
               ? 32'(mem[addr[3:2]][rptr[addr[3:2]]]) : 32'h0;
    else if (in_group(addr, adc_seq_pkg::A_COUNT))
      rdata <= {28'h0, cnt[addr[3:2]]};
    else if (soff < adc_seq_pkg::STEP_SPAN && soff[1:0] == 2'b00)
      rdata <= {25'h0, cfg[soff[6:5]][soff[4:2]]};
    else
      unique case (addr)
        adc_seq_pkg::A_ENABLE:   rdata <= {28'h0, en};
        adc_seq_pkg::A_PRIO:     rdata <= {24'h0, prio};
        adc_seq_pkg::A_FLAGS:    rdata <= {24'h0, udf, ovf};
        adc_seq_pkg::A_IRQ_RAW:  rdata <= {28'h0, raw};
        adc_seq_pkg::A_IRQ_MASK: rdata <= {28'h0, mask};
        default:                 rdata <= 32'h0;
      endcase
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  property p_ovf_set;
    |(hit & nonempty) |=> ((ovf & $past(hit & nonempty))
                           == $past(hit & nonempty));
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow not flagged");

  property p_ovf_hold;
    !(wr && addr == adc_seq_pkg::A_FLAGS) |=> ((ovf & $past(ovf))
                                              == $past(ovf));
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow dropped without clear");

  property p_udf_set;
    |udf_ev |=> ((udf & $past(udf_ev)) == $past(udf_ev));
  endproperty
  a_udf_set: assert property (p_udf_set)
    else $error("underflow not flagged");

  property p_udf_hold;
    !(wr && addr == adc_seq_pkg::A_FLAGS) |=> ((udf & $past(udf))
                                              == $past(udf));
  endproperty
  a_udf_hold: assert property (p_udf_hold)
    else $error("underflow dropped without clear");

  property p_dis_ignore;
    1'b1 |=> ((pending & ~$past(pending) & ~$past(en)) == 4'h0);
  endproperty
  a_dis_ignore: assert property (p_dis_ignore)
    else $error("disabled sequence became pending");

  property p_en_start;
    state == IDLE && pending == 4'h0 && |hit |=> ##1 state == START;
  endproperty
  a_en_start: assert property (p_en_start)
    else $error("enabled trigger did not start");

  property p_step_range;
    state != IDLE |-> {1'b0, step} < adc_seq_pkg::seq_depth(cur);
  endproperty
  a_step_range: assert property (p_step_range)
    else $error("step past sequence length");

  property p_irq_step;
    push && cs.step_irq_on_done |=> raw[$past(cur)];
  endproperty
  a_irq_step: assert property (p_irq_step)
    else $error("step interrupt not raised");

  property p_last_end;
    push && cs.step_last_marker |=> state == IDLE;
  endproperty
  a_last_end: assert property (p_last_end)
    else $error("end marker did not stop sequence");

  property p_req_cfg;
    state == START |=> conv_start && conv_req.chan ==
      $past(cs.step_input_sel) && conv_req.diff == $past(cs.step_diff_sel);
  endproperty
  a_req_cfg: assert property (p_req_cfg)
    else $error("conversion request mismatches step");

  property p_cnt_max;
    cnt[0] <= 4'd8 && cnt[1] <= 4'd4 && cnt[2] <= 4'd4 && cnt[3] <= 4'd1;
  endproperty
  a_cnt_max: assert property (p_cnt_max)
    else $error("FIFO count past depth");

  property p_irq_out;
    1'b1 |=> irq == |($past(raw) & $past(mask));
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("irq does not follow masked status");

  c_overflow: cover property (|(hit & nonempty));
  c_underflow: cover property (|udf_ev);
  c_full_seq0: cover property (cnt[0] == 4'd8);
  c_irq: cover property ($rose(irq));
endmodule : adc_sample_sequencer
`default_nettype wire

// ### rtl/adc_seq_pkg.sv
// Register map, step layout and shared types of the sample sequencer
`default_nettype none
package adc_seq_pkg;
  localparam int NSEQ      = 4;
  localparam int MAX_STEPS = 8;

  // Register byte addresses
  localparam logic [7:0] A_ENABLE   = 8'h00;
  localparam logic [7:0] A_PRIO     = 8'h04;
  localparam logic [7:0] A_FLAGS    = 8'h08;
  localparam logic [7:0] A_IRQ_RAW  = 8'h0C;
  localparam logic [7:0] A_IRQ_MASK = 8'h10;
  localparam logic [7:0] A_SWTRIG   = 8'h14;
  localparam logic [7:0] A_FIFO     = 8'h20;
  localparam logic [7:0] A_COUNT    = 8'h30;
  localparam logic [7:0] A_STEP     = 8'h40;
  localparam logic [7:0] STEP_SPAN  = 8'h80;

  // Flag register layout
  localparam int F_OVF = 0;
  localparam int F_UDF = 4;

  // Reset values
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [7:0] PRIO_RST   = 8'hE4;
  localparam logic [3:0] MASK_RST   = 4'h0;

  typedef struct packed {
    logic       step_irq_on_done;
    logic       step_last_marker;
    logic       step_temp_sensor_sel;
    logic       step_diff_sel;
    logic [2:0] step_input_sel;
  } step_t;

  typedef struct packed {
    logic [2:0] chan;
    logic       diff;
    logic       temp;
  } conv_req_t;

  // Steps per trigger and FIFO depth of each sequence
  function automatic logic [3:0] seq_depth(input logic [1:0] s);
    unique case (s)
      2'd0: return 4'd8;
      2'd1: return 4'd4;
      2'd2: return 4'd4;
      2'd3: return 4'd1;
    endcase
  endfunction : seq_depth
endpackage : adc_seq_pkg
`default_nettype wire

// ### verification/adc_core_model.sv
// Behavioural analog core that answers each conversion request once
`default_nettype none
module adc_core_model #(
  parameter int SAMPLE_W = 12
) (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   slow,
  input  wire logic                   conv_start,
  input  wire adc_seq_pkg::conv_req_t conv_req,
  output var  logic                   conv_done,
  output var  logic [SAMPLE_W-1:0]    conv_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic                   busy;
  logic [2:0]             wait_left;
  adc_seq_pkg::conv_req_t held;

  // Sample encodes the request so the bench sees which input was taken
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      busy      <= 1'b0;
      wait_left <= 3'h0;
      held      <= '0;
      conv_done <= 1'b0;
      conv_data <= '0;
    end
    else
    begin
      conv_done <= 1'b0;
      // Idle data keeps moving so a stale sample never looks valid
      conv_data <= ~conv_data;
      if (conv_start)
      begin
        busy      <= 1'b1;
        wait_left <= slow ? 3'h5 : 3'h0;
        held      <= conv_req;
      end
      else if (busy && wait_left != 3'h0)
        wait_left <= wait_left - 3'h1;
      else if (busy)
      begin
        busy      <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= SAMPLE_W'({4'hC, 3'h0, held});
      end
    end
  end
endmodule : adc_core_model
`default_nettype wire

// ### verification/adc_sample_sequencer_tb.sv
// Self-checking bench of the sample sequencer
`default_nettype none
module adc_sample_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clock;
  logic                   nrst;
  logic                   wr;
  logic                   rd;
  logic                   slow;
  logic                   conv_start;
  logic                   conv_done;
  logic                   irq;
  logic [7:0]             addr;
  logic [31:0]            wdata;
  logic [31:0]            rdata;
  logic [31:0]            rv;
  logic [3:0]             trig;
  logic [11:0]            conv_data;
  adc_seq_pkg::conv_req_t conv_req;
  adc_seq_pkg::conv_req_t first_req;
  logic [20:0]            rows [6];
  int                     err_total;
  int                     cmp_count;
  int                     i;

  adc_sample_sequencer i_dut (.clock(clock), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trig(trig),
    .conv_start(conv_start), .conv_req(conv_req), .conv_done(conv_done),
    .conv_data(conv_data), .irq(irq));

  adc_core_model i_core (.clock(clock), .nrst(nrst), .slow(slow),
    .conv_start(conv_start), .conv_req(conv_req), .conv_done(conv_done),
    .conv_data(conv_data));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [7:0] fifo_a(input logic [1:0] s);
    return adc_seq_pkg::A_FIFO + {4'h0, s, 2'h0};
  endfunction : fifo_a

  function automatic logic [7:0] cnt_a(input logic [1:0] s);
    return adc_seq_pkg::A_COUNT + {4'h0, s, 2'h0};
  endfunction : cnt_a

  function automatic logic [7:0] step_a(input logic [1:0] s, input int t);
    return adc_seq_pkg::A_STEP + {1'b0, s, 5'h0} + 8'(4 * t);
  endfunction : step_a

  function automatic logic [31:0] exp_of(input logic [6:0] cfg);
    return {20'h0, 4'hC, 3'h0, cfg[2:0], cfg[3], cfg[4]};
  endfunction : exp_of

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    check(v, exp);
  endtask : rd_check

  // Polls the sample count; a count that never arrives ends the run
  task automatic wait_count(input logic [1:0] s, input logic [31:0] n);
    logic [31:0] v;
    for (int k = 0; k < 200; k++)
    begin
      rd_reg(cnt_a(s), v);
      if (v === n)
        return;
    end
    check(v, n);
    complete_run();
  endtask : wait_count

  task automatic pulse_trig(input logic [3:0] v);
    @(posedge clock);
    trig <= v;
    @(posedge clock);
    trig <= 4'h0;
  endtask : pulse_trig

  initial
  begin
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; slow = 1'b0;
    addr = 8'h00; wdata = 32'h0; trig = 4'h0;
    err_total = 0; cmp_count = 0;
    // Sequence, step setting, expected sample
    rows[0] = {2'd0, 7'h27, 12'hC1C};
    rows[1] = {2'd1, 7'h21, 12'hC04};
    rows[2] = {2'd2, 7'h28, 12'hC02};
    rows[3] = {2'd3, 7'h30, 12'hC01};
    rows[4] = {2'd0, 7'h29, 12'hC06};
    rows[5] = {2'd1, 7'h23, 12'hC0C};
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    rd_check(adc_seq_pkg::A_ENABLE, 32'h0);
    rd_check(adc_seq_pkg::A_PRIO, 32'hE4);
    rd_check(adc_seq_pkg::A_FLAGS, 32'h0);
    rd_check(8'hFC, 32'h0);
    check({31'h0, irq}, 32'h0);
    for (i = 0; i < 6; i++)
    begin
      wr_reg(adc_seq_pkg::A_ENABLE, 32'h0);
      wr_reg(step_a(rows[i][20:19], 0), {25'h0, rows[i][18:12]});
      wr_reg(adc_seq_pkg::A_ENABLE, 32'(4'h1 << rows[i][20:19]));
      wr_reg(adc_seq_pkg::A_SWTRIG, 32'(4'h1 << rows[i][20:19]));
      wait_count(rows[i][20:19], 32'h1);
      rd_check(fifo_a(rows[i][20:19]), {20'h0, rows[i][11:0]});
      rd_check(cnt_a(rows[i][20:19]), 32'h0);
    end
    // Eight steps in order under a slow core
    slow <= 1'b1;
    wr_reg(adc_seq_pkg::A_ENABLE, 32'h0);
    for (i = 0; i < 8; i++)
      wr_reg(step_a(2'd0, i), 32'(i));
    wr_reg(adc_seq_pkg::A_ENABLE, 32'h1);
    pulse_trig(4'h1);
    wait_count(2'd0, 32'h8);
    repeat (30) @(posedge clock);
    rd_check(cnt_a(2'd0), 32'h8);
    for (i = 0; i < 8; i++)
      rd_check(fifo_a(2'd0), exp_of(7'(i)));
    slow <= 1'b0;
    // End marker on step 1 stops after two samples
    for (i = 0; i < 4; i++)
      wr_reg(step_a(2'd1, i), (i == 1) ? 32'h25 : 32'(i + 4));
    wr_reg(adc_seq_pkg::A_ENABLE, 32'h2);
    wr_reg(adc_seq_pkg::A_SWTRIG, 32'h2);
    wait_count(2'd1, 32'h2);
    repeat (30) @(posedge clock);
    rd_check(cnt_a(2'd1), 32'h2);
    rd_check(fifo_a(2'd1), exp_of(7'h04));
    rd_check(fifo_a(2'd1), exp_of(7'h05));
    wr_reg(step_a(2'd3, 1), 32'h7F);
    rd_check(step_a(2'd3, 1), 32'h0);
    // Trigger while a sample is unread
    wr_reg(step_a(2'd3, 0), 32'h22);
    wr_reg(adc_seq_pkg::A_ENABLE, 32'h8);
    pulse_trig(4'h8);
    wait_count(2'd3, 32'h1);
    pulse_trig(4'h8);
    repeat (20) @(posedge clock);
    rd_check(adc_seq_pkg::A_FLAGS, 32'h08);
    rd_check(cnt_a(2'd3), 32'h1);
    rd_check(adc_seq_pkg::A_FLAGS, 32'h08);
    wr_reg(adc_seq_pkg::A_FLAGS, 32'h08);
    rd_check(adc_seq_pkg::A_FLAGS, 32'h0);
    pulse_trig(4'h8);
    repeat (20) @(posedge clock);
    rd_check(adc_seq_pkg::A_FLAGS, 32'h08);
    wr_reg(adc_seq_pkg::A_FLAGS, 32'h08);
    rd_check(fifo_a(2'd3), exp_of(7'h22));
    // Reads past the end of a sequence FIFO
    rd_check(fifo_a(2'd2), 32'h0);
    rd_check(adc_seq_pkg::A_FLAGS, 32'h40);
    rd_check(fifo_a(2'd2), 32'h0);
    rd_check(adc_seq_pkg::A_FLAGS, 32'h40);
    wr_reg(adc_seq_pkg::A_FLAGS, 32'h40);
    rd_check(adc_seq_pkg::A_FLAGS, 32'h0);
    // Disabled sequences ignore both trigger kinds
    wr_reg(adc_seq_pkg::A_ENABLE, 32'h0);
    pulse_trig(4'hF);
    wr_reg(adc_seq_pkg::A_SWTRIG, 32'hF);
    repeat (40) @(posedge clock);
    for (i = 0; i < 4; i++)
      rd_check(cnt_a(2'(i)), 32'h0);
    // Interrupt raised, masked, unmasked and cleared
    wr_reg(step_a(2'd3, 0), 32'h61);
    wr_reg(adc_seq_pkg::A_ENABLE, 32'h8);
    wr_reg(adc_seq_pkg::A_SWTRIG, 32'h8);
    wait_count(2'd3, 32'h1);
    repeat (3) @(posedge clock);
    rd_check(adc_seq_pkg::A_IRQ_RAW, 32'h8);
    check({31'h0, irq}, 32'h0);
    wr_reg(adc_seq_pkg::A_IRQ_MASK, 32'h8);
    repeat (2) @(posedge clock);
    #1;
    check({31'h0, irq}, 32'h1);
    wr_reg(adc_seq_pkg::A_IRQ_RAW, 32'h8);
    repeat (2) @(posedge clock);
    #1;
    check({31'h0, irq}, 32'h0);
    rd_check(fifo_a(2'd3), exp_of(7'h61));
    // Sequence 2 outranks sequence 1 when both are pending
    wr_reg(adc_seq_pkg::A_PRIO, 32'h4B);
    wr_reg(step_a(2'd1, 0), 32'h21);
    wr_reg(step_a(2'd2, 0), 32'h22);
    wr_reg(adc_seq_pkg::A_ENABLE, 32'h6);
    wr_reg(adc_seq_pkg::A_SWTRIG, 32'h6);
    first_req = '0;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clock);
      #1;
      if (conv_start === 1'b1)
      begin
        first_req = conv_req;
        break;
      end
    end
    check({27'h0, first_req}, {27'h0, 3'd2, 2'b00});
    wait_count(2'd1, 32'h1);
    wait_count(2'd2, 32'h1);
    rd_check(fifo_a(2'd2), exp_of(7'h22));
    // Reset while idle drops the unread sample and restores priority and enable
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    #1;
    check({27'h0, conv_req}, 32'h0);
    check({31'h0, conv_start}, 32'h0);
    rd_check(cnt_a(2'd1), 32'h0);
    rd_check(adc_seq_pkg::A_PRIO, 32'hE4);
    rd_check(adc_seq_pkg::A_ENABLE, 32'h0);
    complete_run();
  end
endmodule : adc_sample_sequencer_tb
`default_nettype wire
